// ---- dv/test_timer16_core_with_byte_access.sv ----
// Self-checking bench for the timer core
`default_nettype none
module test_timer16_core_with_byte_access
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          mclk, resetn, ce, timer_power_off, ext_count_input, capture_input_pin;
  logic          comparator_out, capture_from_comparator, compare_out_a, compare_out_b;
  logic          at_bottom, at_max, at_top;
  logic [7:0]    rdata, timer_flag_reg, b;
  logic [15:0]   v, w, o1;
  tmr_bus_type   bus;
  tmr_event_type vector_taken, irq;
  int            n_errors, cmp_count, seed, i;

  tmr_cpu_model cpu_u (.mclk(mclk), .bus(bus), .rdata(rdata));
  tmr_core dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .timer_power_off(timer_power_off),
    .bus(bus), .rdata(rdata), .ext_count_input(ext_count_input), .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out), .capture_from_comparator(capture_from_comparator),
    .vector_taken(vector_taken), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
    .timer_flag_reg(timer_flag_reg), .irq(irq), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ========================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] after_ticks(input logic [15:0] start, input int n);
    return start + 16'(n);
  endfunction
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic pulses(input int n);
    repeat (2 * n) begin
      repeat (3) @(posedge mclk);
      ext_count_input <= !ext_count_input;
    end
  endtask
  initial begin
    #500000;
    n_errors++;
    wrap_up();
  end
  // ========================================
  // Scenarios
  initial begin
    seed = 32'h62B3;
    {n_errors, cmp_count} = '0;
    {resetn, timer_power_off, ext_count_input, capture_input_pin, comparator_out, capture_from_comparator} = '0;
    ce = 1'b1;
    vector_taken = '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    cyc(1);
    check("bottom after reset", at_bottom, 1'h1);
    cpu_u.rd16(TMR_ADDR_CAP_L, v);
    check("capture after reset", v, 16'h0000);
    for (i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      cpu_u.wr16(TMR_ADDR_CMA_L, v);
      cpu_u.wr16(TMR_ADDR_CMB_L, ~v);
      cpu_u.wr16(TMR_ADDR_CNT_L, v ^ 16'h5A5A);
      cpu_u.rd16(TMR_ADDR_CMA_L, w);
      check("compare a", w, v);
      cpu_u.rd16(TMR_ADDR_CMB_L, w);
      check("compare b", w, ~v);
      cpu_u.rd16(TMR_ADDR_CNT_L, w);
      check("count", w, v ^ 16'h5A5A);
      cpu_u.rd8(TMR_ADDR_CMA_H, b);
      check("compare a high", b, v[15:8]);
    end
    v[7:0] = 8'($random(seed)) & 8'hF0;
    cpu_u.wr8(TMR_ADDR_CTL_A, v[7:0]);
    cpu_u.rd8(TMR_ADDR_CTL_A, b);
    check("control a", b, v[7:0]);
    cpu_u.rd8(TMR_ADDR_CTL_C, b);
    check("control c", b, 16'h0000);
    cpu_u.rd8(4'hF, b);
    check("unmapped", b, 16'h0000);
    cpu_u.wr8(TMR_ADDR_CTL_A, 8'h00);
    // Overflow in normal mode at full rate
    cpu_u.wr8(TMR_ADDR_MASK, 8'h21);
    cpu_u.wr16(TMR_ADDR_CNT_L, 16'hFFF0);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h01);
    for (i = 0; i < 40 && at_max !== 1'b1; i++) cyc(1);
    check("reaches max", at_max, 1'h1);
    check("max is top", at_top, 1'h1);
    for (i = 0; i < 4 && at_bottom !== 1'b1; i++) cyc(1);
    check("wraps to bottom", at_bottom, 1'h1);
    cyc(2);
    check("overflow flag", timer_flag_reg[TMR_BIT_OVF], 1'h1);
    check("overflow request", irq.ovf, 1'h1);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h00);
    // Capture on a rising pin, then filtered
    cpu_u.wr16(TMR_ADDR_CNT_L, 16'h3C5A);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h40);
    capture_input_pin <= 1'b1;
    cyc(8);
    check("capture flag", timer_flag_reg[TMR_BIT_CAP], 1'h1);
    check("capture request", irq.cap, 1'h1);
    cpu_u.rd16(TMR_ADDR_CAP_L, v);
    check("capture value", v, 16'h3C5A);
    cpu_u.wr8(TMR_ADDR_FLAG, 8'h20);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'hC0);
    check("flag cleared", timer_flag_reg[TMR_BIT_CAP], 1'h0);
    capture_input_pin <= 1'b0;
    @(posedge mclk);
    capture_input_pin <= 1'b1;
    cyc(10);
    check("glitch filtered", timer_flag_reg[TMR_BIT_CAP], 1'h0);
    capture_input_pin <= 1'b0;
    cyc(10);
    capture_input_pin <= 1'b1;
    cyc(12);
    check("filtered edge", timer_flag_reg[TMR_BIT_CAP], 1'h1);
    capture_from_comparator <= 1'b1;
    cpu_u.wr8(TMR_ADDR_FLAG, 8'h20);
    cyc(8);
    comparator_out <= 1'b1;
    cyc(12);
    check("comparator edge", timer_flag_reg[TMR_BIT_CAP], 1'h1);
    // External clock, stop, power off
    cpu_u.wr16(TMR_ADDR_CNT_L, 16'h0100);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h07);
    pulses(5);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h00);
    pulses(3);
    cpu_u.rd16(TMR_ADDR_CNT_L, v);
    check("external count", v, after_ticks(16'h0100, 5));
    timer_power_off <= 1'b1;
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h01);
    cyc(20);
    cpu_u.rd16(TMR_ADDR_CNT_L, v);
    check("count powered off", v, after_ticks(16'h0100, 5));
    vector_taken <= '{ovf: 1'b1, cmp_a: 1'b0, cmp_b: 1'b0, cap: 1'b0};
    @(posedge mclk);
    vector_taken <= '0;
    cpu_u.wr8(TMR_ADDR_FLAG, 8'h20);
    cyc(1);
    check("flags cleared", timer_flag_reg & 8'h21, 16'h0000);
    timer_power_off <= 1'b0;
    // Clear on compare A, both outputs toggle
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h00);
    cpu_u.wr16(TMR_ADDR_CMA_L, 16'h0008);
    cpu_u.wr16(TMR_ADDR_CMB_L, 16'h0004);
    cpu_u.wr16(TMR_ADDR_CNT_L, 16'h0000);
    cpu_u.wr8(TMR_ADDR_FLAG, 8'h06);
    cpu_u.wr8(TMR_ADDR_CTL_A, 8'h50);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h09);
    for (i = 0; i < 30 && at_top !== 1'b1; i++) cyc(1);
    check("top at compare a", at_top, 1'h1);
    cyc(2);
    check("compare flags", timer_flag_reg[TMR_BIT_CMB:TMR_BIT_CMA], 2'h3);
    o1 = {compare_out_b, compare_out_a};
    for (i = 0; i < 30 && at_top !== 1'b1; i++) cyc(1);
    cyc(2);
    check("outputs toggled", {compare_out_b, compare_out_a}, o1 ^ 16'h0003);
    // PWM, compare A as top: output low
    cpu_u.wr8(TMR_ADDR_CTL_A, 8'hC3);
    cpu_u.wr8(TMR_ADDR_CTL_B, 8'h19);
    v = '0;
    repeat (40) begin
      cyc(1);
      v = v + 16'(compare_out_a);
    end
    check("no pwm on a", v, 16'h0000);
    wrap_up();
  end
endmodule // test_timer16_core_with_byte_access
`default_nettype wire

// ---- dv/tmr_core_props.sv ----
// Concurrent checks on the timer core ports
`default_nettype none
module tmr_core_props
  import tmr_pkg::*;
(
  input wire logic          mclk,
  input wire logic          resetn,
  input wire logic          ce,
  input wire logic          timer_power_off,
  input wire tmr_bus_type   bus,
  input wire logic [7:0]    rdata,
  input wire tmr_event_type vector_taken,
  input wire logic [7:0]    timer_flag_reg,
  input wire tmr_event_type irq,
  input wire logic          at_bottom,
  input wire logic          at_max,
  input wire logic          at_top
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic rd_go;
  logic wr_go;
  assign rd_go = ce && bus.rd;
  assign wr_go = ce && bus.wr;
  // ========================================
  // Port relations
  a_rdata_holds: assert property (!rd_go |=> $stable(rdata))
    else $error("read data moved");
  a_ctlc_reads_zero: assert property (rd_go && bus.addr == TMR_ADDR_CTL_C |=> rdata == 8'h00)
    else $error("control C read not zero");
  a_unmapped_zero: assert property (rd_go && bus.addr > TMR_ADDR_MASK |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Mode writes may move the top
  a_power_freeze: assert property (timer_power_off && !wr_go |=> $stable({at_bottom, at_max, at_top}))
    else $error("moved while off");
  a_irq_ovf_gated: assert property (irq.ovf |-> timer_flag_reg[TMR_BIT_OVF])
    else $error("overflow request without flag");
  a_irq_cap_gated: assert property (irq.cap |-> timer_flag_reg[TMR_BIT_CAP])
    else $error("capture request without flag");
  a_vector_clear: assert property (ce && vector_taken.ovf && timer_power_off |=> !timer_flag_reg[TMR_BIT_OVF])
    else $error("overflow flag kept");
  a_write_one_clears: assert property (wr_go && bus.addr == TMR_ADDR_FLAG && bus.wdata[TMR_BIT_CAP]
    && timer_power_off |=> !timer_flag_reg[TMR_BIT_CAP])
    else $error("capture flag kept");
  a_reset_bottom: assert property ($rose(resetn) |-> at_bottom && timer_flag_reg == 8'h00)
    else $error("not clear after reset");
  a_ends_exclusive: assert property (!(at_bottom && at_max))
    else $error("bottom and max together");
endmodule // tmr_core_props
bind tmr_core tmr_core_props u_props (.mclk(mclk), .resetn(resetn), .ce(ce), .timer_power_off(timer_power_off),
  .bus(bus), .rdata(rdata), .vector_taken(vector_taken), .timer_flag_reg(timer_flag_reg), .irq(irq),
  .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
`default_nettype wire

// ---- dv/tmr_cpu_model.sv ----
// Processor model driving the byte-wide register port
`default_nettype none
module tmr_cpu_model
  import tmr_pkg::*;
(
  input  wire logic       mclk,
  output var tmr_bus_type bus,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus = '0;
  // Accesses never interleave, so the latch stays intact
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask
endmodule // tmr_cpu_model
`default_nettype wire

// ---- rtl/tmr_compare_unit.sv ----
// One double-buffered compare unit with waveform output
`default_nettype none
module tmr_compare_unit
  import tmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] wdata,
  input  wire logic        pwm_mode,
  input  wire logic        reload,
  input  wire logic        tick,
  input  wire logic [15:0] count,
  input  wire logic [1:0]  out_mode,
  input  wire logic        force_match,
  input  wire logic        out_block,
  output logic [15:0]      value,
  output logic             match,
  output logic             wave
);
  logic [15:0] buffer;

  assign match = (count == value);

  // ==========================================
  // Buffer, taken into use at TOP in PWM modes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      buffer <= TMR_RESET16;
      value  <= TMR_RESET16;
    end else if (ce) begin
      if (load) begin
        buffer <= wdata;
      end
      if (load && !pwm_mode) begin
        value <= wdata;
      end else if (pwm_mode && reload && tick) begin
        value <= buffer;
      end
    end
  end

  // ==========================================
  // Waveform: 01 toggle outside PWM modes, 10 clear on match, 11 set on match
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wave <= 1'b0;
    end else if (ce && !out_block) begin
      if (pwm_mode) begin
        if (tick && reload) begin
          wave <= (out_mode == 2'b10);
        end else if (tick && match) begin
          wave <= (out_mode == 2'b11);
        end
      end else if ((tick && match) || force_match) begin
        unique case (out_mode)
          2'b01:   wave <= ~wave;
          2'b10:   wave <= 1'b0;
          2'b11:   wave <= 1'b1;
          default: wave <= wave;
        endcase
      end
    end
  end
endmodule // tmr_compare_unit
`default_nettype wire

// ---- rtl/tmr_core.sv ----
// Top of the 16-bit timer core: counter, capture, flags and byte access
`default_nettype none
module tmr_core
  import tmr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        timer_power_off,
  input  wire tmr_bus_type bus,
  output logic [7:0]       rdata,
  input  wire logic        ext_count_input,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_out,
  input  wire logic        capture_from_comparator,
  input  wire tmr_event_type vector_taken,
  output logic             compare_out_a,
  output logic             compare_out_b,
  output logic [7:0]       timer_flag_reg,
  output tmr_event_type    irq,
  output logic             at_bottom,
  output logic             at_max,
  output logic             at_top
);
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [7:0]  high_latch;
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [7:0]  timer_control_c;
  logic [7:0]  timer_mask_reg;
  logic [9:0]  prescale;
  logic [1:0]  ext_sync;
  logic        ext_prev;
  logic [1:0]  cap_sync;
  logic [1:0]  cmp_sync;
  logic        cap_raw;
  logic [TMR_FILT_LEN-1:0] filt_shift;
  logic        filt_out;
  logic        cap_prev;
  logic        cap_event;
  logic        run;
  logic        timer_tick;
  logic [3:0]  wave_mode;
  tmr_cs_type  clock_select;
  logic        pwm_mode;
  logic [15:0] top_value;
  logic        top_from_a;
  logic        cnt_write;
  logic        cap_write;
  logic        match_a;
  logic        match_b;
  logic        wave_a;
  logic        wave_b;
  logic        block_match;
  tmr_event_type set_ev;
  logic [7:0]  next_rdata;
  logic [15:0] wr_word;

  assign run          = ce && !timer_power_off;
  assign wave_mode    = {timer_control_b[TMR_CB_WGH_LSB +: 2], timer_control_a[TMR_CA_WGL_LSB +: 2]};
  assign clock_select = tmr_cs_type'(timer_control_b[TMR_CB_CS_LSB +: 3]);
  assign wr_word      = {high_latch, bus.wdata};
  assign cnt_write    = bus.wr && (bus.addr == TMR_ADDR_CNT_L);
  assign cap_write    = bus.wr && (bus.addr == TMR_ADDR_CAP_L);

  // ==========================================
  // Mode decode
  always_comb begin
    pwm_mode   = 1'b0;
    top_from_a = 1'b0;
    top_value  = TMR_MAX;
    unique case (wave_mode)
      TMR_WG_CTC_A: begin
        top_value  = compare_value_a;
        top_from_a = 1'b1;
      end
      TMR_WG_CTC_CAP: top_value = capture_value;
      TMR_WG_FPWM8: begin
        top_value = TMR_TOP_8BIT;
        pwm_mode  = 1'b1;
      end
      TMR_WG_FPWM_CAP: begin
        top_value = capture_value;
        pwm_mode  = 1'b1;
      end
      TMR_WG_FPWM_A: begin
        top_value  = compare_value_a;
        top_from_a = 1'b1;
        pwm_mode   = 1'b1;
      end
      default: top_value = TMR_MAX;
    endcase
  end

  assign at_bottom = (count_value == TMR_BOTTOM);
  assign at_max    = (count_value == TMR_MAX);
  assign at_top    = (count_value == top_value);

  // ==========================================
  // Clock select: prescaler and external edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prescale <= '0;
    end else if (run) begin
      prescale <= prescale + 10'd1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
      cap_sync <= 2'b00;
      cmp_sync <= 2'b00;
    end else if (ce) begin
      ext_sync <= {ext_sync[0], ext_count_input};
      ext_prev <= ext_sync[1];
      cap_sync <= {cap_sync[0], capture_input_pin};
      cmp_sync <= {cmp_sync[0], comparator_out};
    end
  end

  always_comb begin
    timer_tick = 1'b0;
    unique case (clock_select)
      TMR_CS_NONE:     timer_tick = 1'b0;
      TMR_CS_DIV1:     timer_tick = 1'b1;
      TMR_CS_DIV8:     timer_tick = ((prescale & TMR_PRE_MASK_8) == TMR_PRE_MASK_8);
      TMR_CS_DIV64:    timer_tick = ((prescale & TMR_PRE_MASK_64) == TMR_PRE_MASK_64);
      TMR_CS_DIV256:   timer_tick = ((prescale & TMR_PRE_MASK_256) == TMR_PRE_MASK_256);
      TMR_CS_DIV1024:  timer_tick = (prescale == TMR_PRE_MASK_1024);
      TMR_CS_EXT_FALL: timer_tick = ext_prev && !ext_sync[1];
      TMR_CS_EXT_RISE: timer_tick = !ext_prev && ext_sync[1];
    endcase
    timer_tick = timer_tick && run;
  end

  // ==========================================
  // Counter, CPU write wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_value <= TMR_RESET16;
    end else if (run) begin
      if (cnt_write) begin
        count_value <= wr_word;
      end else if (timer_tick) begin
        count_value <= at_top ? TMR_BOTTOM : count_value + 16'd1;
      end
    end
  end

  // Match suppressed on the tick right after a counter write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      block_match <= 1'b0;
    end else if (run) begin
      if (cnt_write) begin
        block_match <= 1'b1;
      end else if (timer_tick) begin
        block_match <= 1'b0;
      end
    end
  end

  // ==========================================
  // Capture input: source select, filter, edge
  assign cap_raw = capture_from_comparator ? cmp_sync[1] : cap_sync[1];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      filt_shift <= '0;
      filt_out   <= 1'b0;
      cap_prev   <= 1'b0;
    end else if (run) begin
      filt_shift <= {filt_shift[TMR_FILT_LEN-2:0], cap_raw};
      // Level accepted only after four equal samples
      if (&filt_shift) begin
        filt_out <= 1'b1;
      end else if (~|filt_shift) begin
        filt_out <= 1'b0;
      end
      cap_prev <= timer_control_b[TMR_CB_FILT] ? filt_out : cap_raw;
    end
  end

  always_comb begin
    logic lvl;
    lvl       = timer_control_b[TMR_CB_FILT] ? filt_out : cap_raw;
    cap_event = run && (timer_control_b[TMR_CB_EDGE] ? (lvl && !cap_prev) : (!lvl && cap_prev));
  end

  // Capture register doubles as TOP, so only those modes let software write it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      capture_value <= TMR_RESET16;
    end else if (run) begin
      if (cap_write && (wave_mode == TMR_WG_CTC_CAP || wave_mode == TMR_WG_FPWM_CAP)) begin
        capture_value <= wr_word;
      end else if (cap_event && wave_mode != TMR_WG_CTC_CAP && wave_mode != TMR_WG_FPWM_CAP) begin
        capture_value <= count_value;
      end
    end
  end

  // ==========================================
  // Compare units
  tmr_compare_unit u_cmp_a (
    .mclk        (mclk),
    .resetn      (resetn),
    .ce          (run),
    .load        (bus.wr && bus.addr == TMR_ADDR_CMA_L),
    .wdata       (wr_word),
    .pwm_mode    (pwm_mode),
    .reload      (at_top),
    .tick        (timer_tick && !block_match),
    .count       (count_value),
    .out_mode    (timer_control_a[TMR_CA_OMA_LSB +: 2]),
    .force_match (bus.wr && bus.addr == TMR_ADDR_CTL_C && bus.wdata[TMR_CC_FOA]),
    .out_block   (top_from_a && pwm_mode),
    .value       (compare_value_a),
    .match       (match_a),
    .wave        (wave_a)
  );

  tmr_compare_unit u_cmp_b (
    .mclk        (mclk),
    .resetn      (resetn),
    .ce          (run),
    .load        (bus.wr && bus.addr == TMR_ADDR_CMB_L),
    .wdata       (wr_word),
    .pwm_mode    (pwm_mode),
    .reload      (at_top),
    .tick        (timer_tick && !block_match),
    .count       (count_value),
    .out_mode    (timer_control_a[TMR_CA_OMB_LSB +: 2]),
    .force_match (bus.wr && bus.addr == TMR_ADDR_CTL_C && bus.wdata[TMR_CC_FOB]),
    .out_block   (1'b0),
    .value       (compare_value_b),
    .match       (match_b),
    .wave        (wave_b)
  );

  // No PWM on compare A while it defines TOP
  assign compare_out_a = (top_from_a && pwm_mode) ? 1'b0 : wave_a;
  assign compare_out_b = wave_b;

  // ==========================================
  // Control registers and shared latch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_control_a <= TMR_RESET8;
      timer_control_b <= TMR_RESET8;
      timer_control_c <= TMR_RESET8;
      timer_mask_reg  <= TMR_RESET8;
    end else if (ce && bus.wr) begin
      unique case (bus.addr)
        TMR_ADDR_CTL_A: timer_control_a <= bus.wdata;
        TMR_ADDR_CTL_B: timer_control_b <= bus.wdata;
        TMR_ADDR_CTL_C: timer_control_c <= bus.wdata;
        TMR_ADDR_MASK:  timer_mask_reg  <= bus.wdata;
        default:        timer_mask_reg  <= timer_mask_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      high_latch <= TMR_RESET8;
    end else if (ce) begin
      if (bus.wr && (bus.addr == TMR_ADDR_CNT_H || bus.addr == TMR_ADDR_CMA_H ||
                     bus.addr == TMR_ADDR_CMB_H || bus.addr == TMR_ADDR_CAP_H)) begin
        high_latch <= bus.wdata;
      end else if (bus.rd && bus.addr == TMR_ADDR_CNT_L) begin
        high_latch <= count_value[15:8];
      end else if (bus.rd && bus.addr == TMR_ADDR_CAP_L) begin
        high_latch <= capture_value[15:8];
      end
    end
  end

  // ==========================================
  // Flags: hardware set beats a clear in the same cycle
  assign set_ev.ovf   = timer_tick && (pwm_mode ? at_top : at_max);
  assign set_ev.cmp_a = timer_tick && !block_match && match_a;
  assign set_ev.cmp_b = timer_tick && !block_match && match_b;
  assign set_ev.cap   = cap_event && wave_mode != TMR_WG_CTC_CAP && wave_mode != TMR_WG_FPWM_CAP;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_flag_reg <= TMR_RESET8;
    end else if (ce) begin
      timer_flag_reg[TMR_BIT_OVF] <= set_ev.ovf || (timer_flag_reg[TMR_BIT_OVF] && !vector_taken.ovf &&
        !(bus.wr && bus.addr == TMR_ADDR_FLAG && bus.wdata[TMR_BIT_OVF]));
      timer_flag_reg[TMR_BIT_CMA] <= set_ev.cmp_a || (timer_flag_reg[TMR_BIT_CMA] && !vector_taken.cmp_a &&
        !(bus.wr && bus.addr == TMR_ADDR_FLAG && bus.wdata[TMR_BIT_CMA]));
      timer_flag_reg[TMR_BIT_CMB] <= set_ev.cmp_b || (timer_flag_reg[TMR_BIT_CMB] && !vector_taken.cmp_b &&
        !(bus.wr && bus.addr == TMR_ADDR_FLAG && bus.wdata[TMR_BIT_CMB]));
      timer_flag_reg[TMR_BIT_CAP] <= set_ev.cap || (timer_flag_reg[TMR_BIT_CAP] && !vector_taken.cap &&
        !(bus.wr && bus.addr == TMR_ADDR_FLAG && bus.wdata[TMR_BIT_CAP]));
    end
  end

  assign irq.ovf   = timer_flag_reg[TMR_BIT_OVF] && timer_mask_reg[TMR_BIT_OVF];
  assign irq.cmp_a = timer_flag_reg[TMR_BIT_CMA] && timer_mask_reg[TMR_BIT_CMA];
  assign irq.cmp_b = timer_flag_reg[TMR_BIT_CMB] && timer_mask_reg[TMR_BIT_CMB];
  assign irq.cap   = timer_flag_reg[TMR_BIT_CAP] && timer_mask_reg[TMR_BIT_CAP];

  // ==========================================
  // Read data, registered one cycle after the read strobe
  always_comb begin
    next_rdata = 8'h00;
    unique case (bus.addr)
      TMR_ADDR_CNT_L: next_rdata = count_value[7:0];
      TMR_ADDR_CNT_H: next_rdata = high_latch;
      TMR_ADDR_CMA_L: next_rdata = compare_value_a[7:0];
      TMR_ADDR_CMA_H: next_rdata = compare_value_a[15:8];
      TMR_ADDR_CMB_L: next_rdata = compare_value_b[7:0];
      TMR_ADDR_CMB_H: next_rdata = compare_value_b[15:8];
      TMR_ADDR_CAP_L: next_rdata = capture_value[7:0];
      TMR_ADDR_CAP_H: next_rdata = high_latch;
      TMR_ADDR_CTL_A: next_rdata = timer_control_a;
      TMR_ADDR_CTL_B: next_rdata = timer_control_b;
      TMR_ADDR_CTL_C: next_rdata = 8'h00;
      TMR_ADDR_FLAG:  next_rdata = timer_flag_reg;
      TMR_ADDR_MASK:  next_rdata = timer_mask_reg;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (ce && bus.rd) begin
      rdata <= next_rdata;
    end
  end
endmodule // tmr_core
`default_nettype wire

// ---- rtl/tmr_pkg.sv ----
// Package: constants and carrier types of the 16-bit timer core
// Functional notes
// - Counter value zero is BOTTOM.
// - Counter value all ones is MAX.
// - TOP flagged when counter equals sequence top: MAX, 0x00FF, compare A or capture.
// - Power-off bit one holds counter, prescaler, capture and compare units idle.
// - Tick comes from prescaler or external input, with selectable edge.
// - No counting when clock select chooses no source.
// - Both buffered compare registers compared continuously; match sets its flag.
// - Each compare output drives a waveform derived from its match.
// - Four flags, overflow, compare A, compare B, capture, each maskable.
// - Capture edge copies counter into capture register; pin or comparator.
// - Selectable noise filter ahead of capture edge detector.
// - TOP from compare A, capture or fixed; compare A then drives no PWM.
// - Compare A as TOP is double buffered in mode 15 only; mode 4 loads it directly.
// - One shared high-byte latch for all 16-bit registers.
// - Low-byte write loads latch and written byte together.
// - Counter or capture low-byte read copies high byte into latch; high read returns latch.
// - Compare register high-byte reads bypass the latch.
// - Control registers are plain byte access.
// - CPU counter write beats clear and count in same cycle.
// - Capture flag sets in the cycle the capture value is stored.
`default_nettype none
package tmr_pkg;
  localparam logic [15:0] TMR_BOTTOM     = 16'h0000;
  localparam logic [15:0] TMR_MAX        = 16'hFFFF;
  localparam logic [15:0] TMR_RESET16    = 16'h0000;
  localparam logic [7:0]  TMR_RESET8     = 8'h00;
  // Byte addresses on the 8-bit register port
  localparam logic [3:0]  TMR_ADDR_CNT_L = 4'h0;
  localparam logic [3:0]  TMR_ADDR_CNT_H = 4'h1;
  localparam logic [3:0]  TMR_ADDR_CMA_L = 4'h2;
  localparam logic [3:0]  TMR_ADDR_CMA_H = 4'h3;
  localparam logic [3:0]  TMR_ADDR_CMB_L = 4'h4;
  localparam logic [3:0]  TMR_ADDR_CMB_H = 4'h5;
  localparam logic [3:0]  TMR_ADDR_CAP_L = 4'h6;
  localparam logic [3:0]  TMR_ADDR_CAP_H = 4'h7;
  localparam logic [3:0]  TMR_ADDR_CTL_A = 4'h8;
  localparam logic [3:0]  TMR_ADDR_CTL_B = 4'h9;
  localparam logic [3:0]  TMR_ADDR_CTL_C = 4'hA;
  localparam logic [3:0]  TMR_ADDR_FLAG  = 4'hB;
  localparam logic [3:0]  TMR_ADDR_MASK  = 4'hC;
  // Flag and mask bit positions
  localparam int TMR_BIT_OVF = 0;
  localparam int TMR_BIT_CMA = 1;
  localparam int TMR_BIT_CMB = 2;
  localparam int TMR_BIT_CAP = 5;
  // Control A: [7:6] out mode A, [5:4] out mode B, [1:0] low mode bits
  localparam int TMR_CA_OMA_LSB = 6;
  localparam int TMR_CA_OMB_LSB = 4;
  localparam int TMR_CA_WGL_LSB = 0;
  // Control B: [7] filter, [6] capture edge, [4:3] high mode bits, [2:0] clock select
  localparam int TMR_CB_FILT    = 7;
  localparam int TMR_CB_EDGE    = 6;
  localparam int TMR_CB_WGH_LSB = 3;
  localparam int TMR_CB_CS_LSB  = 0;
  // Control C: [7] force compare A, [6] force compare B
  localparam int TMR_CC_FOA     = 7;
  localparam int TMR_CC_FOB     = 6;
  localparam int TMR_FILT_LEN   = 4;
  localparam logic [9:0] TMR_PRE_MASK_8    = 10'h007;
  localparam logic [9:0] TMR_PRE_MASK_64   = 10'h03F;
  localparam logic [9:0] TMR_PRE_MASK_256  = 10'h0FF;
  localparam logic [9:0] TMR_PRE_MASK_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    TMR_CS_NONE, TMR_CS_DIV1, TMR_CS_DIV8, TMR_CS_DIV64,
    TMR_CS_DIV256, TMR_CS_DIV1024, TMR_CS_EXT_FALL, TMR_CS_EXT_RISE
  } tmr_cs_type;

  // Waveform modes: 0 normal, 4 clear on compare A, 12 clear on capture,
  // 5 fast PWM 8-bit, 14 fast PWM top capture, 15 fast PWM top compare A
  localparam logic [3:0] TMR_WG_NORMAL   = 4'h0;
  localparam logic [3:0] TMR_WG_CTC_A    = 4'h4;
  localparam logic [3:0] TMR_WG_FPWM8    = 4'h5;
  localparam logic [3:0] TMR_WG_CTC_CAP  = 4'hC;
  localparam logic [3:0] TMR_WG_FPWM_CAP = 4'hE;
  localparam logic [3:0] TMR_WG_FPWM_A   = 4'hF;
  localparam logic [15:0] TMR_TOP_8BIT   = 16'h00FF;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tmr_bus_type;

  typedef struct packed {
    logic ovf;
    logic cmp_a;
    logic cmp_b;
    logic cap;
  } tmr_event_type;
endpackage : tmr_pkg
`default_nettype wire
